//--- rrx_pkg.sv
package rrx_pkg;

	localparam int DATA_W  = 8;
	localparam int PC_W    = 11;
	localparam int RADDR_W = 6;
	localparam int LEVEL_W = 4;

	// Cycle counts per instruction
	localparam int RET_CYCLES = 2;
	localparam int ROT_CYCLES = 1;

	// Destination select encoding
	localparam logic DEST_WORK = 1'b0;
	localparam logic DEST_FILE = 1'b1;

	// Reset values
	localparam logic [7:0]  WORK_RESET  = 8'h00;
	localparam logic [10:0] PC_RESET    = 11'h000;
	localparam logic        FLAG_RESET  = 1'b0;

	typedef enum logic [2:0] {
		RRX_OP_NONE,
		RRX_OP_LITERAL_EXIT,
		RRX_OP_SUBROUTINE_EXIT,
		RRX_OP_ROTATE_LEFT,
		RRX_OP_ROTATE_RIGHT
	} rrx_op_t;

	// Decoded instruction from the decoder
	typedef struct packed {
		rrx_op_t      op;
		logic [7:0]   imm;
		logic [5:0]   raddr;
		logic         dest_sel;
	} rrx_instr_t;

	// Register file write request
	typedef struct packed {
		logic         we;
		logic [5:0]   addr;
		logic [7:0]   data;
	} rrx_file_wr_t;

endpackage

//--- rrx_exec.sv
`timescale 1ns/1ps
module rrx_exec (
	// Clock and reset
	input  wire logic                clk_i,
	input  wire logic                reset_n_i,
	// Decoder side
	input  wire logic                instr_valid_i,
	input  wire rrx_pkg::rrx_instr_t instr_i,
	output logic                     busy_o,
	output logic                     done_o,
	// Register file read port
	output logic [5:0]               file_raddr_o,
	input  wire logic [7:0]          file_rdata_i,
	// Register file write port
	output rrx_pkg::rrx_file_wr_t    file_wr_o,
	// Return stack
	input  wire logic [10:0]         stack_top_i,
	input  wire logic [3:0]          stack_level_i,
	output logic                     stack_pop_o,
	output logic [3:0]               stack_level_o,
	// Core state
	output logic [10:0]              pc_o,
	output logic                     pc_load_o,
	output logic [7:0]               working_register_o,
	output logic                     shift_out_flag_o,
	output logic                     global_interrupt_enable_o
);

	////////////////////////////////////////////////////////////////////////
	// Reset synchroniser

	logic rst_meta;
	logic rst_n;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencing

	typedef enum logic [1:0] {
		RRX_IDLE,
		RRX_RET2
	} rrx_state_t;

	rrx_state_t state;
	logic       is_ret;
	logic       is_rot;
	logic       take;
	logic [7:0] rot_result;
	logic       rot_flag;

	assign take   = instr_valid_i && (state == RRX_IDLE);
	assign is_ret = (instr_i.op == rrx_pkg::RRX_OP_LITERAL_EXIT)
		|| (instr_i.op == rrx_pkg::RRX_OP_SUBROUTINE_EXIT);
	assign is_rot = (instr_i.op == rrx_pkg::RRX_OP_ROTATE_LEFT)
		|| (instr_i.op == rrx_pkg::RRX_OP_ROTATE_RIGHT);
	assign busy_o = (state != RRX_IDLE);
	assign file_raddr_o = instr_i.raddr;

	// Returns hold for a second cycle so the fetch of the target refills
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state <= RRX_IDLE;
		end else begin
			case (state)
				RRX_IDLE: begin
					if (take && is_ret) begin
						state <= RRX_RET2;
					end
				end
				RRX_RET2: begin
					state <= RRX_IDLE;
				end
				default: begin
					state <= RRX_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			done_o <= 1'b0;
		end else begin
			done_o <= (state == RRX_RET2) || (take && is_rot);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Rotate datapath

	always_comb begin
		rot_result = file_rdata_i;
		rot_flag   = shift_out_flag_o;
		if (instr_i.op == rrx_pkg::RRX_OP_ROTATE_LEFT) begin
			rot_result = {file_rdata_i[6:0], shift_out_flag_o};
			rot_flag   = file_rdata_i[7];
		end else if (instr_i.op == rrx_pkg::RRX_OP_ROTATE_RIGHT) begin
			rot_result = {shift_out_flag_o, file_rdata_i[7:1]};
			rot_flag   = file_rdata_i[0];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			shift_out_flag_o <= rrx_pkg::FLAG_RESET;
		end else if (take && is_rot) begin
			shift_out_flag_o <= rot_flag;
		end
	end

	// Same select drives both rotates
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			file_wr_o <= '0;
		end else begin
			file_wr_o.we   <= take && is_rot
				&& (instr_i.dest_sel == rrx_pkg::DEST_FILE);
			file_wr_o.addr <= instr_i.raddr;
			file_wr_o.data <= rot_result;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			working_register_o <= rrx_pkg::WORK_RESET;
		end else if (take && instr_i.op == rrx_pkg::RRX_OP_LITERAL_EXIT) begin
			working_register_o <= instr_i.imm;
		end else if (take && is_rot && instr_i.dest_sel == rrx_pkg::DEST_WORK) begin
			working_register_o <= rot_result;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Return path

	// Pop strobe, level and PC all register at the end of the first cycle
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pc_o          <= rrx_pkg::PC_RESET;
			pc_load_o     <= 1'b0;
			stack_pop_o   <= 1'b0;
			stack_level_o <= '0;
		end else begin
			pc_load_o   <= take && is_ret;
			stack_pop_o <= take && is_ret;
			if (take && is_ret) begin
				pc_o          <= stack_top_i;
				stack_level_o <= stack_level_i - 4'h1;
			end
		end
	end

	// Only the literal exit touches interrupt enable; no interrupt entry here
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			global_interrupt_enable_o <= 1'b0;
		end else if (take && instr_i.op == rrx_pkg::RRX_OP_LITERAL_EXIT) begin
			global_interrupt_enable_o <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions

	AST_LIT_WORK: assert property (@(posedge clk_i) disable iff (!rst_n)
		take && instr_i.op == rrx_pkg::RRX_OP_LITERAL_EXIT
		|=> working_register_o == $past(instr_i.imm))
		else $error("literal exit did not load immediate");

	AST_LIT_GIE: assert property (@(posedge clk_i) disable iff (!rst_n)
		take && instr_i.op == rrx_pkg::RRX_OP_LITERAL_EXIT
		|=> global_interrupt_enable_o && busy_o ##1 !busy_o && done_o)
		else $error("literal exit enable or length wrong");

	AST_RET_PC: assert property (@(posedge clk_i) disable iff (!rst_n)
		take && instr_i.op == rrx_pkg::RRX_OP_SUBROUTINE_EXIT
		|=> pc_o == $past(stack_top_i) && pc_load_o && $stable(shift_out_flag_o)
		##1 done_o)
		else $error("subroutine exit wrong");

	AST_ROL: assert property (@(posedge clk_i) disable iff (!rst_n)
		take && instr_i.op == rrx_pkg::RRX_OP_ROTATE_LEFT
		|=> shift_out_flag_o == $past(file_rdata_i[7]) && done_o)
		else $error("left rotate flag wrong");

	AST_ROL_DEST: assert property (@(posedge clk_i) disable iff (!rst_n)
		take && instr_i.op == rrx_pkg::RRX_OP_ROTATE_LEFT && instr_i.dest_sel
		|=> file_wr_o.we
		&& file_wr_o.data == {$past(file_rdata_i[6:0]), $past(shift_out_flag_o)})
		else $error("left rotate file write wrong");

	AST_ROR: assert property (@(posedge clk_i) disable iff (!rst_n)
		take && instr_i.op == rrx_pkg::RRX_OP_ROTATE_RIGHT && !instr_i.dest_sel
		|=> working_register_o == {$past(shift_out_flag_o), $past(file_rdata_i[7:1])}
		&& shift_out_flag_o == $past(file_rdata_i[0]) && !file_wr_o.we)
		else $error("right rotate wrong");

	AST_LEVEL: assert property (@(posedge clk_i) disable iff (!rst_n)
		take && is_ret |=> stack_pop_o && stack_level_o == $past(stack_level_i) - 4'h1)
		else $error("stack level not decremented");

	// A request offered while busy must not start a second pop
	AST_NO_TAKE_BUSY: assert property (@(posedge clk_i) disable iff (!rst_n)
		busy_o |=> !pc_load_o && !stack_pop_o)
		else $error("second pop while busy");

	COV_LIT: cover property (@(posedge clk_i) disable iff (!rst_n)
		take && instr_i.op == rrx_pkg::RRX_OP_LITERAL_EXIT);
	COV_RET: cover property (@(posedge clk_i) disable iff (!rst_n)
		take && instr_i.op == rrx_pkg::RRX_OP_SUBROUTINE_EXIT);
	COV_ROL_FILE: cover property (@(posedge clk_i) disable iff (!rst_n)
		take && instr_i.op == rrx_pkg::RRX_OP_ROTATE_LEFT && instr_i.dest_sel);
	COV_ROR_WORK: cover property (@(posedge clk_i) disable iff (!rst_n)
		take && instr_i.op == rrx_pkg::RRX_OP_ROTATE_RIGHT && !instr_i.dest_sel);

endmodule

//--- rrx_exec_bench.sv
`timescale 1ns/1ps
module rrx_exec_bench;
	logic                  clk_i, reset_n_i, instr_valid_i;
	rrx_pkg::rrx_instr_t   instr_i;
	logic [7:0]            file_rdata_i;
	logic [10:0]           stack_top_i, pc_o;
	logic [3:0]            stack_level_i, stack_level_o;
	logic [5:0]            file_raddr_o;
	rrx_pkg::rrx_file_wr_t file_wr_o;
	logic                  busy_o, done_o, stack_pop_o, pc_load_o;
	logic [7:0]            working_register_o;
	logic                  shift_out_flag_o, global_interrupt_enable_o;
	int                    mismatches, compares;
	logic [15:0]           seed;
	logic                  exp_c, exp_gie, p_on, p_d;
	logic [7:0]            exp_work, p_res;
	logic [5:0]            p_addr;

	rrx_exec u_rrx_exec (.clk_i(clk_i), .reset_n_i(reset_n_i), .instr_valid_i(instr_valid_i),
		.instr_i(instr_i), .busy_o(busy_o), .done_o(done_o), .file_raddr_o(file_raddr_o),
		.file_rdata_i(file_rdata_i), .file_wr_o(file_wr_o), .stack_top_i(stack_top_i),
		.stack_level_i(stack_level_i), .stack_pop_o(stack_pop_o), .stack_level_o(stack_level_o),
		.pc_o(pc_o), .pc_load_o(pc_load_o), .working_register_o(working_register_o),
		.shift_out_flag_o(shift_out_flag_o),
		.global_interrupt_enable_o(global_interrupt_enable_o));

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction

	// Returns {new flag, result}
	function automatic logic [8:0] rot(input logic left, input logic [7:0] r, input logic c);
		return left ? {r[7], r[6:0], c} : {r[0], c, r[7:1]};
	endfunction

	task automatic chk(input string name, input logic [10:0] exp, input logic [10:0] got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic check_pend();
		chk("done", 1, done_o);
		chk("flag", exp_c, shift_out_flag_o);
		chk("we", p_d, file_wr_o.we);
		chk("work", exp_work, working_register_o);
		if (p_d) begin
			chk("addr", p_addr, file_wr_o.addr);
			chk("data", p_res, file_wr_o.data);
		end
	endtask

	// Pipelined: drives one rotate per edge, checks the one taken at that edge
	task automatic rotate(input logic left, input logic d, input logic [7:0] r, input logic [5:0] a);
		logic [8:0] v;
		@(posedge clk_i);
		instr_valid_i <= 1'b1;
		instr_i <= '{left ? rrx_pkg::RRX_OP_ROTATE_LEFT : rrx_pkg::RRX_OP_ROTATE_RIGHT, 8'h00, a, d};
		file_rdata_i <= r;
		#1;
		chk("raddr", a, file_raddr_o);
		if (p_on) check_pend();
		v = rot(left, r, exp_c);
		exp_c = v[8];
		if (!d) exp_work = v[7:0];
		{p_on, p_d, p_res, p_addr} = {1'b1, d, v[7:0], a};
	endtask

	task automatic flush();
		@(posedge clk_i);
		instr_valid_i <= 1'b0;
		#1;
		if (p_on) check_pend();
		p_on = 1'b0;
	endtask

	task automatic ret(input logic lit, input logic [7:0] imm, input logic [10:0] top,
			input logic [3:0] lvl);
		@(posedge clk_i);
		instr_valid_i <= 1'b1;
		instr_i <= '{lit ? rrx_pkg::RRX_OP_LITERAL_EXIT : rrx_pkg::RRX_OP_SUBROUTINE_EXIT, imm, 6'h05, 1'b0};
		stack_top_i <= top;
		stack_level_i <= lvl;
		@(posedge clk_i);
		// Probe while busy: must be ignored
		instr_i <= '{rrx_pkg::RRX_OP_ROTATE_LEFT, 8'h00, 6'h05, 1'b0};
		file_rdata_i <= {8{~exp_c}};
		#1;
		if (lit) exp_work = imm;
		if (lit) exp_gie = 1'b1;
		chk("pc", top, pc_o);
		chk("pc_load", 1, pc_load_o);
		chk("pop", 1, stack_pop_o);
		chk("level", 4'(lvl - 4'h1), stack_level_o);
		chk("busy", 1, busy_o);
		chk("work", exp_work, working_register_o);
		chk("gie", exp_gie, global_interrupt_enable_o);
		@(posedge clk_i);
		instr_valid_i <= 1'b0;
		#1;
		chk("done", 1, done_o);
		chk("busy", 0, busy_o);
		chk("pop", 0, stack_pop_o);
		chk("flag", exp_c, shift_out_flag_o);
		chk("we", 0, file_wr_o.we);
		chk("work", exp_work, working_register_o);
	endtask

	task automatic stop_test();
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{reset_n_i, instr_valid_i, file_rdata_i, stack_top_i, stack_level_i} = '0;
		instr_i = '0;
		{mismatches, compares} = '0;
		{exp_c, exp_gie, p_on, exp_work} = '0;
		seed = 16'hada2;
		repeat (5) @(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		#1;
		chk("gie", 0, global_interrupt_enable_o);
		rotate(1'b1, 1'b1, 8'ha5, 6'h3f);
		rotate(1'b0, 1'b0, 8'h01, 6'h00);
		// Random back-to-back rotates, both directions and destinations
		for (int i = 0; i < 60; i++) begin
			seed = lfsr(seed);
			rotate(seed[0], seed[1], seed[15:8], seed[7:2]);
		end
		flush();
		// Idle opcode with valid high must leave everything alone
		@(posedge clk_i);
		instr_valid_i <= 1'b1;
		instr_i <= '{rrx_pkg::RRX_OP_NONE, 8'hff, 6'h2a, 1'b1};
		file_rdata_i <= 8'hff;
		@(posedge clk_i);
		instr_valid_i <= 1'b0;
		#1;
		chk("done", 0, done_o);
		chk("pop", 0, stack_pop_o);
		chk("we", 0, file_wr_o.we);
		chk("flag", exp_c, shift_out_flag_o);
		chk("work", exp_work, working_register_o);
		ret(1'b0, 8'h00, 11'h7ff, 4'h0);
		ret(1'b1, 8'h55, 11'h2a5, 4'h2);
		rotate(1'b0, 1'b1, 8'h80, 6'h11);
		flush();
		stop_test();
	end

	// Runs needs roughly 80 cycles
	initial begin
		repeat (2000) @(posedge clk_i);
		mismatches++;
		stop_test();
	end
endmodule
